// >>> verilog/ttt_tracker.v
// Target-side transfer tracker: outstanding transfer table, read sender, completions.
// Assumes all inputs synchronous to clk; the protocol layer honours req_ready and sms_rx_ready.
`timescale 1ns/1ns
`include "ttt_defs.vh"
module ttt_tracker #(
  parameter DEPTH  = `TTT_TBL_DEPTH,
  parameter CHN    = `TTT_TBL_CHN,
  parameter TAG_W  = `TTT_TAG_W,
  parameter CH_W   = `TTT_CHAN_W,
  parameter RP_W   = `TTT_RPID_W,
  parameter UID_W  = `TTT_UID_W,
  parameter CNT_W  = `TTT_CNT_W,
  parameter DW     = `TTT_DATA_W,
  parameter FIFO_D = `TTT_FIFO_D,
  parameter LIX_W  = `TTT_LUT_IDX_W
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rstn,
  // Transfer requests from the protocol layer
  input  wire             rd_req,
  input  wire             wr_req,
  input  wire             frd_req,
  input  wire [TAG_W-1:0] req_tag,
  input  wire [RP_W-1:0]  req_rpid,
  input  wire [CH_W-1:0]  req_chan,
  input  wire [CNT_W-1:0] req_count,
  output reg              req_ready_q,
  // Read data from the protocol layer
  input  wire             rd_data_valid,
  input  wire [DW-1:0]    rd_data,
  output wire             rd_data_ready,
  // Read data toward the link
  output reg              tx_valid_q,
  output reg  [DW-1:0]    tx_data_q,
  output reg  [CH_W-1:0]  tx_chan_q,
  output reg              tx_last_q,
  input  wire             tx_ready,
  input  wire             tx_err,
  // Write data from the link and toward the protocol layer
  input  wire             rx_valid,
  input  wire [DW-1:0]    rx_data,
  input  wire [CH_W-1:0]  rx_chan,
  input  wire             rx_last,
  input  wire             rx_err,
  output reg              wr_data_valid_q,
  output reg  [DW-1:0]    wr_data_q,
  // Channel setup and teardown
  input  wire             chan_open,
  input  wire [TAG_W-1:0] chan_open_tag,
  input  wire [CH_W-1:0]  chan_open_chan,
  input  wire             chan_close,
  input  wire [CH_W-1:0]  chan_close_chan,
  // Received messages
  input  wire             sms_rx_valid,
  input  wire [2:0]       sms_rx_type,
  input  wire [TAG_W-1:0] sms_rx_tag,
  input  wire [RP_W-1:0]  sms_rx_rpid,
  input  wire [CH_W-1:0]  sms_rx_chan,
  input  wire [CNT_W-1:0] sms_rx_count,
  output reg              sms_rx_ready_q,
  // Transmitted messages
  output reg              sms_tx_valid_q,
  output reg  [2:0]       sms_tx_type_q,
  output reg  [TAG_W-1:0] sms_tx_tag_q,
  output reg  [RP_W-1:0]  sms_tx_rpid_q,
  output reg  [CNT_W-1:0] sms_tx_count_q,
  output reg  [7:0]       sms_tx_code_q,
  input  wire             sms_tx_ready,
  // Quiesce handshake with the protocol layer
  output reg              quiesce_req_q,
  input  wire             quiesce_done,
  input  wire             quiesce_ok,
  // Completions
  output reg              cmp_valid_q,
  output reg  [1:0]       cmp_kind_q,
  output reg  [TAG_W-1:0] cmp_tag_q,
  output reg  [UID_W-1:0] cmp_uid_q,
  output reg  [7:0]       cmp_code_q,
  output reg              err_nomatch_q,
  // Configutor table load
  input  wire             cfg_wr,
  input  wire [LIX_W-1:0] cfg_idx,
  input  wire [UID_W-1:0] cfg_uid,
  // Client registration and asynchronous events
  input  wire             client_register,
  input  wire             event_valid,
  input  wire [7:0]       event_code,
  output reg              async_event_report_q,
  output reg  [7:0]       event_code_q
);
  localparam NE = DEPTH * CHN;
  localparam IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam FW = (NE > 1) ? $clog2(NE) : 1;
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_SEND = 2'h1;
  localparam [1:0] S_QUI  = 2'h2;
  localparam [1:0] S_RESP = 2'h3;

  // Outstanding transfer table.
  reg [DEPTH-1:0] ev_q;
  reg [DEPTH-1:0] ewr_q;
  reg [TAG_W-1:0] etag_q [0:DEPTH-1];
  reg [RP_W-1:0]  erp_q  [0:DEPTH-1];
  reg [NE-1:0]    cv_q;
  reg [CH_W-1:0]  cch_q  [0:NE-1];

  reg [1:0]       st_q;
  reg [CNT_W-1:0] rem_q;
  reg             fast_q;
  reg             fail_q;
  reg [TAG_W-1:0] ftag_q;
  reg [RP_W-1:0]  frp_q;
  reg             client_q;
  reg             wend_q;
  reg [CH_W-1:0]  wend_ch_q;
  reg             wend_fail_q;

  wire            f_valid;
  wire [DW-1:0]   f_data;
  wire            f_pop;
  wire [UID_W-1:0] lut_uid;
  wire            tx_fire = tx_valid_q & tx_ready;
  wire            last_sent = tx_fire & tx_last_q;
  wire            rx_take = sms_rx_valid & sms_rx_ready_q;
  wire            rep_take = rx_take & (sms_rx_type == `TTT_SMS_DATA_REPLY);
  wire            qui_take = rx_take & (sms_rx_type == `TTT_SMS_QUIESCE);
  wire            req_take = req_ready_q & (rd_req | wr_req | frd_req);
  // A normal read end has the lookup; a pending write end waits one more cycle.
  wire            end_rd = last_sent & ~fast_q;
  wire            end_go = end_rd | (wend_q & ~last_sent);
  wire [CH_W-1:0] end_ch = end_rd ? tx_chan_q : wend_ch_q;
  wire            end_wr = ~end_rd;
  wire            end_fail = end_rd ? (fail_q | tx_err) : wend_fail_q;

  wire [DEPTH-1:0] rep_hit;
  wire [DEPTH-1:0] open_hit;
  wire [DEPTH-1:0] multi;
  wire [NE-1:0]    end_hit;
  wire [NE-1:0]    close_hit;

  genvar e, c;
  generate
    for (e = 0; e < DEPTH; e = e + 1)
    begin : g_ent
      assign rep_hit[e]  = ev_q[e] & ~ewr_q[e] & (etag_q[e] == sms_rx_tag) & (erp_q[e] == sms_rx_rpid);
      assign open_hit[e] = ev_q[e] & ewr_q[e] & (etag_q[e] == chan_open_tag);
      assign multi[e]    = |(cv_q[e*CHN +: CHN] & (cv_q[e*CHN +: CHN] - {{(CHN-1){1'b0}}, 1'b1}));
      for (c = 0; c < CHN; c = c + 1)
      begin : g_ch
        assign end_hit[e*CHN+c]   = cv_q[e*CHN+c] & (cch_q[e*CHN+c] == end_ch) & (ewr_q[e] == end_wr);
        assign close_hit[e*CHN+c] = cv_q[e*CHN+c] & (cch_q[e*CHN+c] == chan_close_chan);
      end
    end
  endgenerate

  // Priority encoders over the table.
  reg          has_free;
  reg [IW-1:0] free_e;
  reg          rep_ok;
  reg [IW-1:0] rep_e;
  reg          open_ok;
  reg [IW-1:0] open_e;
  reg          end_ok;
  reg [IW-1:0] end_e;
  reg [FW-1:0] end_i;
  reg [IW-1:0] add_e;
  reg          add_ok;
  reg          add_dup;
  reg [FW-1:0] add_i;
  reg [CH_W-1:0] add_ch;
  integer i;
  integer j;
  integer k;
  integer r;

  always @*
  begin
    has_free = 1'b0;
    k        = 0;
    free_e   = {IW{1'b0}};
    rep_ok   = 1'b0;
    rep_e    = {IW{1'b0}};
    open_ok  = 1'b0;
    open_e   = {IW{1'b0}};
    end_ok   = 1'b0;
    end_e    = {IW{1'b0}};
    end_i    = {FW{1'b0}};
    for (i = DEPTH - 1; i >= 0; i = i - 1)
    begin
      if (!ev_q[i])
      begin
        has_free = 1'b1;
        free_e   = i[IW-1:0];
      end
      if (rep_hit[i])
      begin
        rep_ok = 1'b1;
        rep_e  = i[IW-1:0];
      end
      if (open_hit[i])
      begin
        open_ok = 1'b1;
        open_e  = i[IW-1:0];
      end
      for (j = CHN - 1; j >= 0; j = j - 1)
      begin
        if (end_hit[i*CHN+j])
        begin
          end_ok = 1'b1;
          end_e  = i[IW-1:0];
          k      = i * CHN + j;
          end_i  = k[FW-1:0];
        end
      end
    end
    // A reply adds its channel to the read entry; otherwise a write channel setup does.
    add_e   = rep_take ? rep_e : open_e;
    add_ch  = rep_take ? sms_rx_chan : chan_open_chan;
    add_ok  = 1'b0;
    add_dup = 1'b0;
    add_i   = {FW{1'b0}};
    for (j = CHN - 1; j >= 0; j = j - 1)
    begin
      if (!cv_q[add_e*CHN+j])
      begin
        add_ok = 1'b1;
        k      = add_e * CHN + j;
        add_i  = k[FW-1:0];
      end
      else if (cch_q[add_e*CHN+j] == add_ch)
        add_dup = 1'b1;
    end
  end

  ttt_fifo #(
    .W (DW),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (rd_data_valid),
    .in_data   (rd_data),
    .in_ready  (rd_data_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_pop)
  );

  ttt_cfg_lut #(
    .IDX_W (LIX_W),
    .UID_W (UID_W)
  ) u_lut (
    .clk    (clk),
    .rstn   (rstn),
    .wr_en  (cfg_wr),
    .wr_idx (cfg_idx),
    .wr_uid (cfg_uid),
    .rd_idx (end_go ? erp_q[end_e][LIX_W-1:0] : frp_q[LIX_W-1:0]),
    .rd_uid (lut_uid)
  );

  // In S_SEND with bytes left, the output stage is refilled whenever it is empty or being taken, so the link sees one byte a cycle.
  assign f_pop = (st_q == S_SEND) & f_valid & (rem_q != {CNT_W{1'b0}}) & (~tx_valid_q | tx_ready);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ev_q <= {DEPTH{1'b0}};
      ewr_q <= {DEPTH{1'b0}};
      cv_q <= {NE{1'b0}};
      for (r = 0; r < DEPTH; r = r + 1)
      begin
        etag_q[r] <= {TAG_W{1'b0}};
        erp_q[r]  <= {RP_W{1'b0}};
      end
      for (r = 0; r < NE; r = r + 1)
        cch_q[r] <= {CH_W{1'b0}};
      st_q <= S_IDLE;
      rem_q <= {CNT_W{1'b0}};
      fast_q <= 1'b0;
      fail_q <= 1'b0;
      ftag_q <= {TAG_W{1'b0}};
      frp_q <= {RP_W{1'b0}};
      client_q <= 1'b0;
      wend_q <= 1'b0;
      wend_ch_q <= {CH_W{1'b0}};
      wend_fail_q <= 1'b0;
      req_ready_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_data_q <= {DW{1'b0}};
      tx_chan_q <= {CH_W{1'b0}};
      tx_last_q <= 1'b0;
      wr_data_valid_q <= 1'b0;
      wr_data_q <= {DW{1'b0}};
      sms_rx_ready_q <= 1'b0;
      sms_tx_valid_q <= 1'b0;
      sms_tx_type_q <= 3'h0;
      sms_tx_tag_q <= {TAG_W{1'b0}};
      sms_tx_rpid_q <= {RP_W{1'b0}};
      sms_tx_count_q <= {CNT_W{1'b0}};
      sms_tx_code_q <= 8'h00;
      quiesce_req_q <= 1'b0;
      cmp_valid_q <= 1'b0;
      cmp_kind_q <= `TTT_CMP_NONE;
      cmp_tag_q <= {TAG_W{1'b0}};
      cmp_uid_q <= {UID_W{1'b0}};
      cmp_code_q <= 8'h00;
      err_nomatch_q <= 1'b0;
      async_event_report_q <= 1'b0;
      event_code_q <= 8'h00;
    end
    else
    begin
      cmp_valid_q <= 1'b0;
      err_nomatch_q <= 1'b0;
      if (sms_tx_valid_q & sms_tx_ready)
        sms_tx_valid_q <= 1'b0;
      // Write data path and end of write capture.
      wr_data_valid_q <= rx_valid;
      wr_data_q <= rx_data;
      if (rx_valid & rx_last)
      begin
        wend_q <= 1'b1;
        wend_ch_q <= rx_chan;
        wend_fail_q <= rx_err;
      end
      else if (end_go & ~end_rd)
        wend_q <= 1'b0;
      // New transfer request.
      if (req_take & (rd_req | wr_req))
      begin
        ev_q[free_e] <= 1'b1;
        ewr_q[free_e] <= wr_req;
        etag_q[free_e] <= req_tag;
        erp_q[free_e] <= req_rpid;
        sms_tx_valid_q <= 1'b1;
        sms_tx_type_q <= wr_req ? `TTT_SMS_DATA_REQUEST : `TTT_SMS_DATA_READY;
        sms_tx_tag_q <= req_tag;
        sms_tx_rpid_q <= req_rpid;
        sms_tx_count_q <= req_count;
        sms_tx_code_q <= `TTT_RC_SUCCESS;
      end
      // Teardown goes first so a same-cycle add is not undone.
      if (chan_close)
        cv_q <= cv_q & ~close_hit;
      if ((rep_take & rep_ok) | (~rep_take & chan_open & open_ok))
      begin
        if (add_ok & ~add_dup)
        begin
          cv_q[add_i] <= 1'b1;
          cch_q[add_i] <= add_ch;
        end
      end
      if ((rep_take & ~rep_ok) | (~rep_take & chan_open & ~open_ok))
        err_nomatch_q <= 1'b1;
      // Ended handling for normal reads and writes.
      if (end_go)
      begin
        if (!end_ok)
          err_nomatch_q <= 1'b1;
        else if (multi[end_e])
          cv_q[end_i] <= 1'b0;
        else
        begin
          cv_q[end_i] <= 1'b0;
          ev_q[end_e] <= 1'b0;
          cmp_valid_q <= 1'b1;
          cmp_kind_q <= end_wr ? `TTT_CMP_WRITE : `TTT_CMP_READ;
          cmp_tag_q <= etag_q[end_e];
          cmp_uid_q <= lut_uid;
          cmp_code_q <= end_fail ? `TTT_RC_FAILED : `TTT_RC_SUCCESS;
        end
      end
      // Read sender and quiesce sequencer.
      if (tx_fire)
        tx_valid_q <= 1'b0;
      if (f_pop)
      begin
        tx_valid_q <= 1'b1;
        tx_data_q <= f_data;
        tx_last_q <= (rem_q == {{(CNT_W-1){1'b0}}, 1'b1});
        rem_q <= rem_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
      case (st_q)
        S_IDLE:
        begin
          if (rep_take & rep_ok & (sms_rx_count != {CNT_W{1'b0}}))
          begin
            st_q <= S_SEND;
            fast_q <= 1'b0;
            fail_q <= 1'b0;
            rem_q <= sms_rx_count;
            tx_chan_q <= sms_rx_chan;
          end
          else if (req_take & frd_req)
          begin
            st_q <= S_SEND;
            fast_q <= 1'b1;
            fail_q <= 1'b0;
            rem_q <= req_count;
            tx_chan_q <= req_chan;
            ftag_q <= req_tag;
            frp_q <= req_rpid;
          end
          else if (qui_take)
          begin
            st_q <= S_QUI;
            quiesce_req_q <= 1'b1;
          end
        end
        S_SEND:
        begin
          if (tx_valid_q & tx_err)
            fail_q <= 1'b1;
          if (last_sent)
          begin
            st_q <= S_IDLE;
            if (fast_q)
            begin
              cmp_valid_q <= 1'b1;
              cmp_kind_q <= `TTT_CMP_FAST;
              cmp_tag_q <= ftag_q;
              cmp_uid_q <= lut_uid;
              cmp_code_q <= (fail_q | tx_err) ? `TTT_RC_FAILED : `TTT_RC_SUCCESS;
            end
          end
        end
        S_QUI:
        begin
          if (quiesce_done)
          begin
            quiesce_req_q <= 1'b0;
            st_q <= S_RESP;
            sms_tx_code_q <= quiesce_ok ? `TTT_RC_SUCCESS : `TTT_RC_FAILED;
          end
        end
        default:
        begin
          if (~sms_tx_valid_q | sms_tx_ready)
          begin
            sms_tx_valid_q <= 1'b1;
            sms_tx_type_q <= `TTT_SMS_RESPONSE;
            st_q <= S_IDLE;
          end
        end
      endcase
      // Ready flags are recomputed for the next cycle; a taken item drops them for at least one cycle.
      sms_rx_ready_q <= (st_q == S_IDLE) & ~rx_take & ~req_take;
      req_ready_q <= (st_q == S_IDLE) & ~rx_take & ~req_take & has_free & ~sms_tx_valid_q;
      // Events reach the client only once it has registered.
      if (client_register)
        client_q <= 1'b1;
      async_event_report_q <= event_valid & client_q;
      if (event_valid)
        event_code_q <= event_code;
    end
  end
endmodule // ttt_tracker

// >>> verilog/ttt_defs.vh
// Constants shared by the target transfer tracker and its helper modules.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TTT_DEFS_VH
`define TTT_DEFS_VH

// Message type codes on the SMS transmit and receive ports.
`define TTT_SMS_DATA_READY   3'h1
`define TTT_SMS_DATA_REPLY   3'h2
`define TTT_SMS_DATA_REQUEST 3'h3
`define TTT_SMS_QUIESCE      3'h4
`define TTT_SMS_RESPONSE     3'h5

// Return codes reported with completions and responses.
`define TTT_RC_SUCCESS 8'h00
`define TTT_RC_FAILED  8'h01

// Completion kinds.
`define TTT_CMP_NONE  2'h0
`define TTT_CMP_READ  2'h1
`define TTT_CMP_WRITE 2'h2
`define TTT_CMP_FAST  2'h3

// Default widths and sizes.
`define TTT_TAG_W     16
`define TTT_CHAN_W    16
`define TTT_RPID_W    32
`define TTT_UID_W     32
`define TTT_CNT_W     16
`define TTT_DATA_W    8
`define TTT_TBL_DEPTH 4
`define TTT_TBL_CHN   2
`define TTT_FIFO_D    4
`define TTT_LUT_IDX_W 4

`endif

// >>> verilog/ttt_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; in_ready is registered so it can feed a top-level port.
`timescale 1ns/1ns
module ttt_fifo #(
  parameter W = 8,
  parameter D = 4
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rstn,
  // Fill side
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output reg          in_ready,
  // Drain side
  output wire         out_valid,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);
  localparam AW = (D > 1) ? $clog2(D) : 1;

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         push = in_valid & in_ready;
  wire         pop  = out_valid & out_ready;
  wire [AW:0]  cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];

  always @(posedge clk)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_q     <= {AW{1'b0}};
      rp_q     <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wp_q <= (wp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      if (pop)
        rp_q <= (rp_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      cnt_q    <= cnt_d;
      // Registered full flag keeps the upstream ready free of combinational paths.
      in_ready <= (cnt_d != D[AW:0]);
    end
  end
endmodule // ttt_fifo

// >>> verilog/ttt_cfg_lut.v
// Return path identifier to initiator unique identifier lookup table.
// Assumes the table is loaded by the configuration logic through the write port.
`timescale 1ns/1ns
module ttt_cfg_lut #(
  parameter IDX_W = 4,
  parameter UID_W = 32
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rstn,
  // Load port
  input  wire             wr_en,
  input  wire [IDX_W-1:0] wr_idx,
  input  wire [UID_W-1:0] wr_uid,
  // Lookup port, combinational
  input  wire [IDX_W-1:0] rd_idx,
  output wire [UID_W-1:0] rd_uid
);
  localparam N = 1 << IDX_W;

  reg [UID_W-1:0] tbl_q [0:N-1];
  integer i;

  assign rd_uid = tbl_q[rd_idx];

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (i = 0; i < N; i = i + 1)
        tbl_q[i] <= {UID_W{1'b0}};
    end
    else if (wr_en)
      tbl_q[wr_idx] <= wr_uid;
  end
endmodule // ttt_cfg_lut

// >>> test/ttt_tracker_monitor.sv
// Port checker for the transfer tracker, bound into every instance.
// Assumes one clock and the active-low asynchronous rstn.
`timescale 1ns/1ns
module ttt_chk (
  input wire logic        clk, rstn, rd_req, wr_req, frd_req, req_ready_q, tx_valid_q, tx_ready,
  input wire logic        rx_valid, wr_data_valid_q, sms_rx_valid, sms_rx_ready_q, sms_tx_valid_q,
  input wire logic        quiesce_req_q, quiesce_done, quiesce_ok, cmp_valid_q, event_valid,
  input wire logic        async_event_report_q,
  input wire logic [1:0]  cmp_kind_q,
  input wire logic [2:0]  sms_rx_type, sms_tx_type_q,
  input wire logic [7:0]  tx_data_q, rx_data, wr_data_q, sms_tx_code_q, event_code, event_code_q,
  input wire logic [15:0] req_tag, tx_chan_q, sms_tx_tag_q,
  input wire logic [31:0] req_rpid, sms_tx_rpid_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_read_ready: assert property (req_ready_q && rd_req |=> sms_tx_valid_q && sms_tx_type_q == 3'h1)
    else $error("read request sent no ready message");
  a_write_request: assert property (req_ready_q && wr_req |=> sms_tx_valid_q && sms_tx_type_q == 3'h3)
    else $error("write request sent no request message");
  a_entry_fields: assert property (req_ready_q && (rd_req || wr_req) |=>
    sms_tx_tag_q == $past(req_tag) && sms_tx_rpid_q == $past(req_rpid)) else $error("message fields wrong");
  a_fast_quiet: assert property (req_ready_q && frd_req |=> !sms_tx_valid_q [*2])
    else $error("fast read sent a message");
  a_tx_hold: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q) && $stable(tx_chan_q))
    else $error("read byte changed while stalled");
  a_write_forward: assert property (rx_valid |=> wr_data_valid_q && wr_data_q == $past(rx_data))
    else $error("write byte not forwarded");
  a_quiesce_start: assert property (sms_rx_valid && sms_rx_ready_q && sms_rx_type == 3'h4 |=> quiesce_req_q)
    else $error("quiesce not passed on");
  a_quiesce_wait: assert property (quiesce_req_q && !quiesce_done |=> quiesce_req_q)
    else $error("quiesce request dropped early");
  a_quiesce_reply: assert property (quiesce_req_q && quiesce_done |-> ##[1:3] sms_tx_valid_q &&
    sms_tx_type_q == 3'h5 && sms_tx_code_q == (quiesce_ok ? 8'h00 : 8'h01)) else $error("quiesce response wrong");
  a_event_source: assert property (async_event_report_q |-> $past(event_valid) &&
    event_code_q == $past(event_code)) else $error("event report without cause");
  c_read: cover property (cmp_valid_q && cmp_kind_q == 2'h1);
  c_write: cover property (cmp_valid_q && cmp_kind_q == 2'h2);
  c_fast: cover property (cmp_valid_q && cmp_kind_q == 2'h3);
endmodule // ttt_chk
bind ttt_tracker ttt_chk u_chk (.*);

// >>> test/ttt_ini_model.sv
// Behavioural initiator and link: answers messages, takes read bytes, sends write bytes.
// Assumes the bench drives slow and bad, and calls send and wdata between transfers.
`timescale 1ns/1ns
module ttt_ini #(parameter [15:0] RCH = 16'h0021, parameter [15:0] WCH = 16'h0031) (
  input wire logic        clk, slow, bad, sms_tx_valid_q, tx_valid_q, sms_rx_ready_q,
  input wire logic [2:0]  sms_tx_type_q,
  input wire logic [15:0] sms_tx_tag_q, sms_tx_count_q,
  input wire logic [31:0] sms_tx_rpid_q,
  output logic            sms_tx_ready, tx_ready, tx_err, rx_valid, rx_last, rx_err, sms_rx_valid,
  output logic [2:0]      sms_rx_type,
  output logic [7:0]      rx_data,
  output logic [15:0]     rx_chan, sms_rx_tag, sms_rx_chan, sms_rx_count, got,
  output logic [31:0]     sms_rx_rpid
);
  logic [2:0]  t;
  logic [15:0] g, n;
  logic [31:0] p;
  initial got = 16'h0;
  always @(posedge clk) if (tx_valid_q && tx_ready) got <= got + 16'h1;
  task send(input [2:0] ty, input [15:0] tg, input [31:0] rp, input [15:0] ch, input [15:0] ct);
    begin
      {sms_rx_type, sms_rx_tag, sms_rx_rpid, sms_rx_chan, sms_rx_count} = {ty, tg, rp, ch, ct};
      sms_rx_valid = 1;
      while (sms_rx_ready_q !== 1'b1) @(negedge clk);
      @(negedge clk);
      sms_rx_valid = 0;
      // A released message bus must not keep showing the old tag and count.
      sms_rx_tag = ~sms_rx_tag;
      sms_rx_count = ~sms_rx_count;
    end
  endtask
  task wdata(input [15:0] c, input [15:0] cnt);
    int i;
    begin
      for (i = 0; i < cnt; i++) begin
        rx_chan = c;
        rx_data = 8'h60 + i[7:0];
        rx_last = (i == cnt - 1);
        rx_err = bad && rx_last;
        rx_valid = 1;
        @(negedge clk);
        {rx_valid, rx_last, rx_err} = 3'h0;
        rx_data = ~rx_data;
        @(negedge clk);
      end
    end
  endtask
  initial begin
    {sms_tx_ready, tx_ready, tx_err, rx_valid, rx_last, rx_err, sms_rx_valid} = 7'h0;
    {sms_rx_type, rx_data, rx_chan, sms_rx_tag, sms_rx_chan, sms_rx_count, sms_rx_rpid} = 107'h0;
    forever begin
      @(negedge clk);
      tx_ready = !slow || !tx_ready;
      tx_err = bad && tx_valid_q;
      if (sms_tx_valid_q && !sms_tx_ready) begin
        sms_tx_ready = 1;
        {t, g, p, n} = {sms_tx_type_q, sms_tx_tag_q, sms_tx_rpid_q, sms_tx_count_q};
      end else if (sms_tx_ready) begin
        sms_tx_ready = 0;
        if (t == 3'h1) send(3'h2, g, p, RCH, n);
        if (t == 3'h3) wdata(WCH, n);
      end
    end
  end
endmodule // ttt_ini

// >>> test/tb_top.sv
// Self-checking bench for the transfer tracker with the initiator model on its far side.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  logic clk = 0, rstn = 0, slow = 0, bad = 0;
  logic rd_req, wr_req, frd_req, rd_data_valid, chan_open, chan_close, quiesce_done, quiesce_ok;
  logic cfg_wr, client_register, event_valid, tx_ready, tx_err, rx_valid, rx_last, rx_err;
  logic sms_rx_valid, sms_tx_ready, req_ready_q, rd_data_ready, tx_valid_q, tx_last_q, wr_data_valid_q;
  logic sms_rx_ready_q, sms_tx_valid_q, quiesce_req_q, cmp_valid_q, err_nomatch_q, async_event_report_q;
  logic [1:0]  cmp_kind_q;
  logic [2:0]  sms_rx_type, sms_tx_type_q;
  logic [3:0]  cfg_idx;
  logic [7:0]  rd_data, rx_data, tx_data_q, wr_data_q, sms_tx_code_q, cmp_code_q, event_code, event_code_q;
  logic [15:0] req_tag, req_chan, req_count, chan_open_tag, chan_open_chan, chan_close_chan, rx_chan;
  logic [15:0] sms_rx_tag, sms_rx_chan, sms_rx_count, tx_chan_q, sms_tx_tag_q, sms_tx_count_q, cmp_tag_q;
  logic [15:0] got, base;
  logic [31:0] req_rpid, cfg_uid, sms_rx_rpid, sms_tx_rpid_q, cmp_uid_q;
  int fail_count = 0, n_checks = 0, i;
  logic s;
  ttt_tracker u_dut (.*);
  ttt_ini u_ini (.*);
  always #50 clk = ~clk;
  function [31:0] uid(input [31:0] p);
    uid = {28'h1000000, p[3:0]};
  endfunction
  task tally_and_finish;
    begin
      if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task req(input [2:0] k, input [15:0] g, input [31:0] p, input [15:0] c, input [15:0] n);
    begin
      while (req_ready_q !== 1'b1) @(negedge clk);
      {frd_req, wr_req, rd_req, req_tag, req_rpid, req_chan, req_count} = {k, g, p, c, n};
      @(negedge clk);
      {frd_req, wr_req, rd_req} = 3'h0;
    end
  endtask
  task push(input [7:0] b);
    begin
      {rd_data_valid, rd_data} = {1'b1, b};
      while (rd_data_ready !== 1'b1) @(negedge clk);
      @(negedge clk);
      rd_data_valid = 0;
      @(negedge clk);
    end
  endtask
  task exp_cmp(input [1:0] k, input [15:0] g, input [31:0] u, input [7:0] c);
    begin
      for (i = 0; i < 80 && cmp_valid_q !== 1'b1; i++) @(negedge clk);
      `CHK(cmp_valid_q, 1'b1)
      `CHK(cmp_kind_q, k)
      `CHK(cmp_tag_q, g)
      `CHK(cmp_uid_q, u)
      `CHK(cmp_code_q, c)
      @(negedge clk);
    end
  endtask
  task t_read(input [15:0] g, input [31:0] p, input [15:0] n);
    begin
      for (int j = 0; j < n; j++) push(8'h50 + j[7:0]);
      if (n == 4) `CHK(rd_data_ready, 1'b0)
      base = got;
      req(3'h1, g, p, 16'h0, n);
      exp_cmp(2'h1, g, uid(p), {7'h0, bad});
      `CHK(got - base, n)
      `CHK(tx_chan_q, 16'h0021)
    end
  endtask
  task t_fast;
    begin
      push(8'h71);
      push(8'h72);
      base = got;
      req(3'h4, 16'h0f0f, 32'h7, 16'h00c3, 16'h2);
      exp_cmp(2'h3, 16'h0f0f, uid(32'h7), 8'h00);
      `CHK(got - base, 16'h2)
      `CHK(tx_data_q, 8'h72)
    end
  endtask
  task t_write;
    begin
      req(3'h2, 16'h0042, 32'h6, 16'h0, 16'h2);
      {chan_open, chan_open_tag, chan_open_chan} = {1'b1, 16'h0042, 16'h0009};
      @(negedge clk);
      chan_open_chan = 16'h0044;
      @(negedge clk);
      {chan_open, chan_close, chan_close_chan} = {2'h1, 16'h0044};
      @(negedge clk);
      {chan_open, chan_close, chan_open_chan} = {2'h2, 16'h0031};
      @(negedge clk);
      chan_open = 0;
      s = 0;
      repeat (14) @(negedge clk) s = s | cmp_valid_q;
      // Two open channels: ending one must only drop that channel.
      `CHK(s, 1'b0)
      u_ini.wdata(16'h0009, 16'h1);
      exp_cmp(2'h2, 16'h0042, uid(32'h6), 8'h00);
    end
  endtask
  task t_quiesce(input ok);
    begin
      quiesce_ok = ok;
      u_ini.send(3'h4, 16'h0, 32'h0, 16'h0, 16'h0);
      @(negedge clk);
      `CHK(quiesce_req_q, 1'b1)
      quiesce_done = 1;
      @(negedge clk);
      quiesce_done = 0;
      for (i = 0; i < 10 && sms_tx_valid_q !== 1'b1; i++) @(negedge clk);
      `CHK(sms_tx_valid_q, 1'b1)
      `CHK(sms_tx_type_q, 3'h5)
      `CHK(sms_tx_code_q, {7'h0, !ok})
      repeat (3) @(negedge clk);
    end
  endtask
  task t_event(input reg_first);
    begin
      client_register = reg_first;
      @(negedge clk);
      {client_register, event_valid, event_code} = {2'h1, 8'h5a};
      @(negedge clk);
      event_valid = 0;
      `CHK(async_event_report_q, reg_first)
      `CHK(event_code_q, 8'h5a)
    end
  endtask
  task t_nomatch;
    begin
      u_ini.send(3'h2, 16'hdead, 32'h5, 16'h0021, 16'h1);
      `CHK(err_nomatch_q, 1'b1)
    end
  endtask
  initial begin
    {rd_req, wr_req, frd_req, rd_data_valid, chan_open, chan_close, quiesce_done, quiesce_ok} = 8'h0;
    {cfg_wr, client_register, event_valid, event_code, rd_data, cfg_idx, cfg_uid} = 55'h0;
    {req_tag, req_chan, req_count, chan_open_tag, chan_open_chan, chan_close_chan, req_rpid} = 128'h0;
    repeat (6) @(negedge clk);
    rstn = 1;
    for (int j = 5; j < 8; j++) begin
      @(negedge clk);
      {cfg_wr, cfg_idx, cfg_uid} = {1'b1, j[3:0], uid(j)};
    end
    @(negedge clk);
    cfg_wr = 0;
    t_read(16'h1234, 32'h5, 16'h4);
    {slow, bad} = 2'h3;
    t_read(16'h0077, 32'h6, 16'h1);
    {slow, bad} = 2'h0;
    t_fast;
    t_write;
    t_nomatch;
    t_quiesce(1'b1);
    t_quiesce(1'b0);
    t_event(1'b0);
    t_event(1'b1);
    tally_and_finish;
  end
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish;
  end
endmodule // tb_top
